// *** verilog/bbsc_map.vh ***
// Purpose: constants for the buck-boost switch control block
// Assumes: comparator results arrive as synchronous digital levels
// Notes:   thresholds live in the analog comparators; only codes live here
`ifndef BBSC_MAP_VH
`define BBSC_MAP_VH

// ============================================================
// Operating modes, {high bit, low bit} of the mode select pins
`define BBSC_MODE_CCM      2'h0
`define BBSC_MODE_DCM      2'h1
`define BBSC_MODE_BURST    2'h2
`define BBSC_MODE_PASS     2'h3

// ============================================================
// Switching regions
`define BBSC_REG_BUCK      2'h0
`define BBSC_REG_BUCKBOOST 2'h1
`define BBSC_REG_BOOST     2'h2

// ============================================================
// Cycle phases
`define BBSC_PH_ON         1'h0
`define BBSC_PH_OFF        1'h1

// ============================================================
// Pulse skip limit of consecutive skipped cycles
`define BBSC_SKIP_W        4
`define BBSC_SKIP_MAX      4'hf
`define BBSC_SKIP_ONE      4'h1
`define BBSC_SKIP_ZERO     4'h0

`endif

// *** verilog/bbsc_region_sel.v ***
// Purpose: pick buck, buck-boost or boost region with hysteresis
// Assumes: input/output ratio comparators with their own hysteresis bands
// Notes:   region only moves on a cycle start
`include "bbsc_map.vh"

module bbsc_region_sel (
  input  wire       i_mclk,
  input  wire       i_reset_n,
  input  wire       i_cycle_start,
  input  wire       i_in_above_buck_enter,
  input  wire       i_in_below_buck_exit,
  input  wire       i_in_below_boost_enter,
  input  wire       i_in_above_boost_exit,
  output reg  [1:0] o_region
);

  reg [1:0] region_next;

  // ============================================================
  // Region transitions
  // Separate enter and exit thresholds keep the region from chattering
  always @*
  begin
    region_next = o_region;
    case (o_region)
      `BBSC_REG_BUCK:
      begin
        if (i_in_below_buck_exit)
          region_next = `BBSC_REG_BUCKBOOST;
      end
      `BBSC_REG_BOOST:
      begin
        if (i_in_above_boost_exit)
          region_next = `BBSC_REG_BUCKBOOST;
      end
      `BBSC_REG_BUCKBOOST:
      begin
        if (i_in_above_buck_enter)
          region_next = `BBSC_REG_BUCK;
        else if (i_in_below_boost_enter)
          region_next = `BBSC_REG_BOOST;
        else
          region_next = `BBSC_REG_BUCKBOOST;
      end
      default:
        region_next = `BBSC_REG_BUCKBOOST;
    endcase
  end

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_region <= `BBSC_REG_BUCKBOOST;
    else if (i_cycle_start)
      o_region <= region_next;
  end

endmodule // bbsc_region_sel

// *** verilog/bbsc_pass_ctrl.v ***
// Purpose: pass-through window state: switching or top switches held on
// Assumes: settle, overvoltage and discharge comparators are synchronous
// Notes:   restart conditions take priority over entry
`include "bbsc_map.vh"

module bbsc_pass_ctrl (
  input  wire i_mclk,
  input  wire i_reset_n,
  input  wire i_pass_mode,
  input  wire i_startup_done,
  input  wire i_in_window,
  input  wire i_out_settled,
  input  wire i_sense_over_peak,
  input  wire i_current_reg_used,
  input  wire i_monitor_near_limit,
  input  wire i_out_over_input,
  input  wire i_out_discharged,
  output reg  o_hold_on,
  output reg  o_isolated,
  output reg  o_fb_tie
);

  wire restart;

  // Peak current or average current limit forces switching again
  assign restart = i_sense_over_peak
                 | (i_current_reg_used & i_monitor_near_limit);

  // ============================================================
  // Non-switching state and reverse isolation
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_hold_on  <= 1'h0;
      o_isolated <= 1'h0;
    end
    else if (!i_pass_mode)
    begin
      o_hold_on  <= 1'h0;
      o_isolated <= 1'h0;
    end
    else if (o_hold_on)
    begin
      if (restart || !i_in_window)
      begin
        o_hold_on  <= 1'h0;
        o_isolated <= 1'h0;
      end
      else if (o_isolated)
        o_isolated <= ~i_out_discharged;
      else
        o_isolated <= i_out_over_input;
    end
    else if (i_startup_done && i_in_window && i_out_settled && !restart)
      o_hold_on <= 1'h1;
  end

  // Feedback pins stay tied except in pass-through after start-up
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_fb_tie <= 1'h1;
    else
      o_fb_tie <= ~(i_pass_mode & i_startup_done);
  end

endmodule // bbsc_pass_ctrl

// *** verilog/bbsc_switch_ctrl.v ***
// Purpose: four-switch buck-boost gate pattern control
// Assumes: all comparator inputs are synchronous to i_mclk
// Notes:   each cycle has an on phase then an off phase ended by i_cycle_start
`include "bbsc_map.vh"

module bbsc_switch_ctrl (
  input  wire i_mclk,
  input  wire i_reset_n,
  input  wire i_cycle_start,
  input  wire i_mode_select_low_bit,
  input  wire i_mode_select_high_bit,
  input  wire i_soft_start_above_thr,
  input  wire i_startup_done,
  input  wire i_current_trip,
  input  wire i_buck_current_trip,
  input  wire i_sense_below_reverse,
  input  wire i_sense_below_neg_limit,
  input  wire i_primary_below_inhibit,
  input  wire i_primary_above_resume,
  input  wire i_light_load_excess,
  input  wire i_monitor_near_limit,
  input  wire i_current_reg_used,
  input  wire i_in_above_buck_enter,
  input  wire i_in_below_buck_exit,
  input  wire i_in_below_boost_enter,
  input  wire i_in_above_boost_exit,
  input  wire i_in_at_or_below_lower,
  input  wire i_in_at_or_above_upper,
  input  wire i_in_near_window_edge,
  input  wire i_out_settled,
  input  wire i_sense_over_peak,
  input  wire i_out_over_input,
  input  wire i_out_discharged,
  output reg  o_switch_a,
  output reg  o_switch_b,
  output reg  o_switch_c,
  output reg  o_switch_d,
  output reg  o_fb_tie,
  output reg  o_reverse_flag,
  output reg  o_loop_select_buck,
  output reg  o_current_loop_active,
  output reg  o_switching,
  output reg  [1:0] o_mode,
  output wire [1:0] o_region
);

  // ============================================================
  // Declarations
  reg  [1:0]              mode_reg;
  reg                     phase_reg;
  reg                     b_done_reg;
  reg                     d_done_reg;
  reg                     inhibit_reg;
  reg                     rev_enable_reg;
  reg                     skip_hold_reg;
  reg  [`BBSC_SKIP_W-1:0] skip_reg;
  reg  [`BBSC_SKIP_W-1:0] skip_next;
  reg                     a_next;
  reg                     b_next;
  reg                     c_next;
  reg                     d_next;
  reg  [1:0]              eff_region;
  wire [1:0]              mode_pins;
  wire                    pass_mode;
  wire                    dcm_like;
  wire                    rev_event;
  wire                    hold_on;
  wire                    isolated;
  wire                    fb_tie;
  wire                    skip_cycle;
  wire                    active;

  assign mode_pins = {i_mode_select_high_bit, i_mode_select_low_bit};
  assign pass_mode = (mode_reg == `BBSC_MODE_PASS);
  assign dcm_like  = (mode_reg == `BBSC_MODE_DCM) | (mode_reg == `BBSC_MODE_BURST);

  // Reverse current test only counts while a bottom-side or output switch conducts
  // Pass-through while switching handles reverse current like discontinuous mode
  assign rev_event = (o_switch_b | o_switch_d) &
                     ((dcm_like | pass_mode) ? i_sense_below_reverse
                      : (rev_enable_reg ? i_sense_below_neg_limit
                         : i_sense_below_reverse));

  // ============================================================
  // Submodules
  bbsc_region_sel u_region (
    .i_mclk                 (i_mclk),
    .i_reset_n              (i_reset_n),
    .i_cycle_start          (i_cycle_start),
    .i_in_above_buck_enter  (i_in_above_buck_enter),
    .i_in_below_buck_exit   (i_in_below_buck_exit),
    .i_in_below_boost_enter (i_in_below_boost_enter),
    .i_in_above_boost_exit  (i_in_above_boost_exit),
    .o_region               (o_region)
  );

  bbsc_pass_ctrl u_pass (
    .i_mclk               (i_mclk),
    .i_reset_n            (i_reset_n),
    .i_pass_mode          (pass_mode),
    .i_startup_done       (i_startup_done),
    .i_in_window          (~i_in_at_or_below_lower & ~i_in_at_or_above_upper),
    .i_out_settled        (i_out_settled),
    .i_sense_over_peak    (i_sense_over_peak),
    .i_current_reg_used   (i_current_reg_used),
    .i_monitor_near_limit (i_monitor_near_limit),
    .i_out_over_input     (i_out_over_input),
    .i_out_discharged     (i_out_discharged),
    .o_hold_on            (hold_on),
    .o_isolated           (isolated),
    .o_fb_tie             (fb_tie)
  );

  // ============================================================
  // Mode, burst inhibit and reverse enable
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_reg       <= `BBSC_MODE_CCM;
      inhibit_reg    <= 1'h0;
      rev_enable_reg <= 1'h0;
    end
    else
    begin
      if (i_cycle_start)
        mode_reg <= mode_pins;
      // Hysteresis: inhibit below threshold, resume only above the upper level
      if (mode_reg != `BBSC_MODE_BURST)
        inhibit_reg <= 1'h0;
      else if (i_primary_below_inhibit)
        inhibit_reg <= 1'h1;
      else if (i_primary_above_resume)
        inhibit_reg <= 1'h0;
      // Soft-start gate is sticky; a new start-up clears it
      if (!i_startup_done)
        rev_enable_reg <= 1'h0;
      else if (i_soft_start_above_thr)
        rev_enable_reg <= 1'h1;
    end
  end

  // ============================================================
  // Pulse skip: in DCM only, skip while the light-load comparator says too much current, at most 15 cycles in a row
  assign skip_cycle = (mode_reg == `BBSC_MODE_DCM) & i_light_load_excess &
                      (skip_reg != `BBSC_SKIP_MAX);

  always @*
  begin
    skip_next = skip_reg;
    if (i_cycle_start)
    begin
      if (skip_cycle)
        skip_next = skip_reg + `BBSC_SKIP_ONE;
      else
        skip_next = `BBSC_SKIP_ZERO;
    end
  end

  // ============================================================
  // Region seen by the switch pattern
  // Pass-through edges reuse buck-boost interleaving to avoid skipping
  always @*
  begin
    eff_region = o_region;
    if (pass_mode)
    begin
      if (i_in_near_window_edge)
        eff_region = `BBSC_REG_BUCKBOOST;
      else if (i_in_at_or_below_lower)
        eff_region = `BBSC_REG_BOOST;
      else if (i_in_at_or_above_upper)
        eff_region = `BBSC_REG_BUCK;
      else
        eff_region = `BBSC_REG_BUCKBOOST;
    end
  end

  // A skipped cycle stays dark until the next start; inhibit and start-up act at once
  assign active = i_startup_done & ~inhibit_reg &
                  ~(i_cycle_start ? skip_cycle : skip_hold_reg);

  // ============================================================
  // Switch pattern
  always @*
  begin
    a_next = 1'h0;
    b_next = 1'h0;
    c_next = 1'h0;
    d_next = 1'h0;
    if (pass_mode && hold_on && i_startup_done)
    begin
      a_next = ~isolated;
      d_next = ~isolated;
    end
    else if (active)
    begin
      case (eff_region)
        `BBSC_REG_BUCK:
        begin
          d_next = 1'h1;
          a_next = (phase_reg == `BBSC_PH_ON);
          b_next = (phase_reg == `BBSC_PH_OFF) & ~b_done_reg & ~rev_event;
        end
        `BBSC_REG_BOOST:
        begin
          a_next = 1'h1;
          c_next = (phase_reg == `BBSC_PH_ON);
          d_next = (phase_reg == `BBSC_PH_OFF) & ~d_done_reg & ~rev_event;
        end
        default:
        begin
          a_next = (phase_reg == `BBSC_PH_ON);
          c_next = (phase_reg == `BBSC_PH_ON);
          b_next = (phase_reg == `BBSC_PH_OFF) & ~b_done_reg & ~rev_event;
          d_next = (phase_reg == `BBSC_PH_OFF) & ~d_done_reg & ~rev_event;
        end
      endcase
    end
  end

  // ============================================================
  // Cycle phase and outputs
  // Current trip ends the on phase; chosen loop comparator drives it
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      phase_reg             <= `BBSC_PH_OFF;
      b_done_reg            <= 1'h0;
      d_done_reg            <= 1'h0;
      skip_reg              <= `BBSC_SKIP_ZERO;
      skip_hold_reg         <= 1'h0;
      o_switch_a            <= 1'h0;
      o_switch_b            <= 1'h0;
      o_switch_c            <= 1'h0;
      o_switch_d            <= 1'h0;
      o_fb_tie              <= 1'h1;
      o_reverse_flag        <= 1'h0;
      o_loop_select_buck    <= 1'h0;
      o_current_loop_active <= 1'h0;
      o_switching           <= 1'h0;
      o_mode                <= `BBSC_MODE_CCM;
    end
    else
    begin
      skip_reg <= skip_next;
      if (i_cycle_start)
      begin
        phase_reg  <= `BBSC_PH_ON;
        skip_hold_reg <= skip_cycle;
        b_done_reg <= 1'h0;
        d_done_reg <= 1'h0;
      end
      else
      begin
        if ((phase_reg == `BBSC_PH_ON) &&
            (o_loop_select_buck ? i_buck_current_trip : i_current_trip))
          phase_reg <= `BBSC_PH_OFF;
        if (rev_event && o_switch_b)
          b_done_reg <= 1'h1;
        if (rev_event && o_switch_d)
          d_done_reg <= 1'h1;
      end
      o_switch_a            <= a_next;
      o_switch_b            <= b_next;
      o_switch_c            <= c_next;
      o_switch_d            <= d_next;
      o_fb_tie              <= fb_tie;
      o_reverse_flag        <= rev_event;
      o_loop_select_buck    <= pass_mode & (eff_region == `BBSC_REG_BUCK);
      o_current_loop_active <= ~pass_mode & i_current_reg_used & i_monitor_near_limit;
      o_switching           <= ~(pass_mode & hold_on) & active;
      o_mode                <= mode_reg;
    end
  end

endmodule // bbsc_switch_ctrl

// *** bench/bbsc_properties.sv ***
// Purpose: port-level checks for bbsc_switch_ctrl
// Assumes: every signal is synchronous to i_mclk
// Notes:   gate pattern lags the sampled mode and region by one edge
module bbsc_props (
  input wire       i_mclk,
  input wire       i_reset_n,
  input wire       i_cycle_start,
  input wire       i_mode_select_low_bit,
  input wire       i_mode_select_high_bit,
  input wire       i_startup_done,
  input wire       i_sense_below_reverse,
  input wire       i_primary_below_inhibit,
  input wire       o_switch_a,
  input wire       o_switch_b,
  input wire       o_switch_c,
  input wire       o_switch_d,
  input wire       o_fb_tie,
  input wire       o_reverse_flag,
  input wire       o_switching,
  input wire [1:0] o_mode,
  input wire [1:0] o_region
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // ============================================================
  // Mode and region sampling
  AST_MODE_DECODE: assert property (i_cycle_start |=> ##1
    o_mode == {$past(i_mode_select_high_bit, 2), $past(i_mode_select_low_bit, 2)})
    else $error("mode not decoded from pins");
  AST_MODE_HOLD: assert property (!i_cycle_start |=> ##1 $stable(o_mode))
    else $error("mode moved between cycle starts");
  AST_REGION_HOLD: assert property (!i_cycle_start |=> $stable(o_region))
    else $error("region moved between cycle starts");
  // ============================================================
  // Gate patterns
  AST_BUCK_C_OFF: assert property (o_region == 2'h0 && $past(o_region) == 2'h0
    && o_mode != 2'h3 && $past(o_mode) != 2'h3 |-> !o_switch_c)
    else $error("switch C on in buck region");
  AST_BOOST_B_OFF: assert property (o_region == 2'h2 && $past(o_region) == 2'h2
    && o_mode != 2'h3 && $past(o_mode) != 2'h3 |-> !o_switch_b)
    else $error("switch B on in boost region");
  AST_STARTUP_OFF: assert property (!i_startup_done ##1 !i_startup_done |->
    !(o_switch_a || o_switch_b || o_switch_c || o_switch_d))
    else $error("switch on before start-up");
  AST_REV_B: assert property (o_switch_b && i_sense_below_reverse && o_mode == 2'h1
    && !$past(i_cycle_start) |=> !o_switch_b && o_reverse_flag)
    else $error("switch B kept on through reverse current");
  AST_REV_D: assert property (o_switch_d && i_sense_below_reverse && o_mode == 2'h1
    && o_region != 2'h0 && !$past(i_cycle_start) |=> !o_switch_d)
    else $error("switch D kept on through reverse current");
  AST_BURST_OFF: assert property ((o_mode == 2'h2 && i_primary_below_inhibit)[*2]
    |=> !o_switching)
    else $error("switching while burst inhibited");
  AST_FB_TIED: assert property (o_mode != 2'h3 && $past(o_mode) != 2'h3 |-> o_fb_tie)
    else $error("feedbacks untied outside pass-through");
endmodule // bbsc_props

bind bbsc_switch_ctrl bbsc_props u_props (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cycle_start(i_cycle_start),
  .i_mode_select_low_bit(i_mode_select_low_bit),
  .i_mode_select_high_bit(i_mode_select_high_bit), .i_startup_done(i_startup_done),
  .i_sense_below_reverse(i_sense_below_reverse),
  .i_primary_below_inhibit(i_primary_below_inhibit), .o_switch_a(o_switch_a),
  .o_switch_b(o_switch_b), .o_switch_c(o_switch_c), .o_switch_d(o_switch_d),
  .o_fb_tie(o_fb_tie), .o_reverse_flag(o_reverse_flag), .o_switching(o_switching),
  .o_mode(o_mode), .o_region(o_region));

// *** bench/bbsc_bridge_model.sv ***
// Purpose: behavioural bridge, inductor and sense resistor
// Assumes: current is counted in arbitrary steps per clock
// Notes:   no path conducts with all of A..D off, so current snaps to zero
module bbsc_bridge_model #(
  parameter int PEAK = 6
) (
  input  wire  i_clk,
  input  wire  i_reset_n,
  input  wire  i_sw_a,
  input  wire  i_sw_b,
  input  wire  i_sw_c,
  input  wire  i_sw_d,
  input  wire  i_vin_high,
  output logic o_trip,
  output logic o_below_rev,
  output logic o_below_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cur;
  logic rise;
  assign rise = i_sw_a && (i_sw_c || (i_sw_d && i_vin_high));
  always @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) cur <= 0;
    else if (rise) cur <= cur + 1;
    else if (i_sw_b || (i_sw_a && i_sw_d)) cur <= cur - 1;
    else cur <= 0;
  assign o_trip      = cur >= PEAK;
  assign o_below_rev = (i_sw_b || i_sw_d) && cur <= 0;
  assign o_below_neg = cur <= -PEAK;
endmodule // bbsc_bridge_model

// *** bench/bbsc_switch_ctrl_tb.sv ***
// Purpose: directed bench for bbsc_switch_ctrl
// Assumes: inputs change on the falling edge
// Notes:   bridge model supplies the current comparators
module bbsc_switch_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rn, cs, ml, mh, ss, sd, inh, res, lt, mon, creg, be, bx, boe, box;
  logic lo, up, edg, stl, pk, ovi, dis, vh, trip, rev, neg;
  wire  swa, swb, swc, swd, fbt, rfl, lsb, cla, swg;
  wire [1:0] mode, reg_;
  int   mismatches, cmp_count, k;
  // ============================================================
  // Clock, design and bridge
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  bbsc_switch_ctrl dut (.i_mclk(clk), .i_reset_n(rn), .i_cycle_start(cs),
    .i_mode_select_low_bit(ml), .i_mode_select_high_bit(mh),
    .i_soft_start_above_thr(ss), .i_startup_done(sd), .i_current_trip(trip),
    .i_buck_current_trip(trip), .i_sense_below_reverse(rev),
    .i_sense_below_neg_limit(neg), .i_primary_below_inhibit(inh),
    .i_primary_above_resume(res), .i_light_load_excess(lt),
    .i_monitor_near_limit(mon), .i_current_reg_used(creg),
    .i_in_above_buck_enter(be), .i_in_below_buck_exit(bx),
    .i_in_below_boost_enter(boe), .i_in_above_boost_exit(box),
    .i_in_at_or_below_lower(lo), .i_in_at_or_above_upper(up),
    .i_in_near_window_edge(edg), .i_out_settled(stl), .i_sense_over_peak(pk),
    .i_out_over_input(ovi), .i_out_discharged(dis), .o_switch_a(swa),
    .o_switch_b(swb), .o_switch_c(swc), .o_switch_d(swd), .o_fb_tie(fbt),
    .o_reverse_flag(rfl), .o_loop_select_buck(lsb), .o_current_loop_active(cla),
    .o_switching(swg), .o_mode(mode), .o_region(reg_));
  bbsc_bridge_model bridge (.i_clk(clk), .i_reset_n(rn), .i_sw_a(swa),
    .i_sw_b(swb), .i_sw_c(swc), .i_sw_d(swd), .i_vin_high(vh), .o_trip(trip),
    .o_below_rev(rev), .o_below_neg(neg));
  // ============================================================
  // Helpers
  task chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task cyc;
    @(negedge clk) cs = 1;
    @(negedge clk) cs = 0;
    repeat (2) @(negedge clk);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    stop_test;
  end
  // ============================================================
  // Tests
  initial
  begin
    {rn, cs, ml, mh, ss, sd, inh, res, lt, mon, creg, be, bx, boe, box} = 0;
    {lo, up, edg, stl, pk, ovi, dis, vh} = 0;
    repeat (16) @(negedge clk);
    rn = 1;
    chk({swa, swb, swc, swd}, 4'h0, "reset gates");
    chk({fbt, 1'h0, reg_}, 4'h9, "reset tie/region");
    for (k = 0; k < 4; k++)
    begin
      {mh, ml} = k[1:0];
      cyc;
      chk({2'h0, mode}, k[3:0], "mode decode");
      {mh, ml} = ~k[1:0];
      repeat (3) @(negedge clk);
      chk({2'h0, mode}, k[3:0], "mode held");
    end
    chk({swa, swb, swc, swd}, 4'h0, "gates before start-up");
    {sd, ss, ml, mh, be, vh} = 6'h33;
    cyc;
    chk({2'h0, reg_}, 4'h0, "buck region");
    for (k = 0; k < 20 && swa !== 1; k++) @(negedge clk);
    chk({swa, swc, swd}, 3'h5, "buck on phase");
    for (k = 0; k < 40 && swb !== 1; k++) @(negedge clk);
    for (k = 0; k < 40 && swb !== 0; k++) @(negedge clk);
    chk({swb, rfl}, 2'h1, "B ends on reverse");
    repeat (4) @(negedge clk);
    chk({swa, swb}, 2'h0, "B off rest of cycle");
    be = 0;
    cyc;
    chk({2'h0, reg_}, 4'h0, "region hysteresis");
    bx = 1;
    cyc;
    chk({2'h0, reg_}, 4'h1, "buck-boost region");
    {bx, ml} = 2'h1;
    cyc;
    for (k = 0; k < 40 && swb !== 1; k++) @(negedge clk);
    for (k = 0; k < 40 && swb !== 0; k++) @(negedge clk);
    chk({swb, swd, rfl}, 3'h1, "DCM B and D end at zero");
    lt = 1;
    cyc;
    chk({3'h0, swg}, 4'h0, "DCM pulse skip");
    lt = 0;
    {bx, boe, vh, ml} = 4'h4;
    cyc;
    chk({2'h0, reg_}, 4'h2, "boost region");
    for (k = 0; k < 40 && swd !== 1; k++) @(negedge clk);
    chk({swa, swb}, 2'h2, "boost A on B off");
    for (k = 0; k < 40 && swd !== 0; k++) @(negedge clk);
    chk({swa, swd, rfl}, 3'h5, "D ends on reverse");
    {mh, ml, inh} = 3'h5;
    cyc;
    repeat (3) @(negedge clk);
    chk({3'h0, swg}, 4'h0, "burst inhibit");
    inh = 0;
    cyc;
    chk({3'h0, swg}, 4'h0, "burst waits resume");
    res = 1;
    cyc;
    for (k = 0; k < 10 && swg !== 1; k++) @(negedge clk);
    chk({3'h0, swg}, 4'h1, "burst resumes");
    {mh, res, mon, creg} = 4'h3;
    cyc;
    chk({3'h0, cla}, 4'h1, "current loop");
    {mon, mh, ml, boe, box, lo} = 6'h1f;
    cyc;
    repeat (2) @(negedge clk);
    chk({2'h0, lsb, fbt}, 4'h0, "boost loop, tie off");
    {lo, up} = 2'h1;
    cyc;
    chk({3'h0, lsb}, 4'h1, "buck loop");
    edg = 1;
    cyc;
    chk({3'h0, lsb}, 4'h0, "edge interleave");
    edg = 0;
    {up, stl} = 2'h1;
    repeat (4) @(negedge clk);
    chk({swa, swb, swc, swd}, 4'h9, "hold top switches");
    chk({3'h0, swg}, 4'h0, "hold not switching");
    ovi = 1;
    repeat (3) @(negedge clk);
    chk({1'h0, swa, swc, swd}, 4'h0, "isolate on overvoltage");
    {ovi, dis} = 2'h1;
    repeat (4) @(negedge clk);
    chk({swa, swb, swc, swd}, 4'h9, "reconnect");
    pk = 1;
    cyc;
    chk({3'h0, swg}, 4'h1, "peak restart");
    pk = 0;
    repeat (8) @(negedge clk);
    chk({swa, swb, swc, swd}, 4'h9, "hold again");
    {creg, mon} = 2'h3;
    cyc;
    chk({3'h0, swg}, 4'h1, "monitor restart");
    ml = 0;
    cyc;
    repeat (2) @(negedge clk);
    chk({3'h0, fbt}, 4'h1, "tie on exit");
    sd = 0;
    repeat (3) @(negedge clk);
    chk({swa, swb, swc, swd}, 4'h0, "start-up off");
    stop_test;
  end
endmodule // bbsc_switch_ctrl_tb
